// file: hw/sltc_pkg.sv
// Shared constants and types for the serial link transmit configuration block.
// Assumes a byte-wide register port with 9-bit addresses in front of it.
package sltc_pkg;

    // Register addresses
    localparam logic [8:0] ADDR_LINK_CTRL_A  = 9'h142;
    localparam logic [8:0] ADDR_LINK_CTRL_B  = 9'h143;
    localparam logic [8:0] ADDR_TEST_CKSUM   = 9'h144;
    localparam logic [8:0] ADDR_ALIGN_REPEAT = 9'h145;
    localparam logic [8:0] ADDR_DEVICE_ID    = 9'h146;

    // Reset values
    localparam logic [7:0] RST_LINK_CTRL_A  = 8'h00;
    localparam logic [7:0] RST_LINK_CTRL_B  = 8'h00;
    localparam logic [7:0] RST_TEST_CKSUM   = 8'h00;
    localparam logic [7:0] RST_ALIGN_REPEAT = 8'h00;
    localparam logic [7:0] RST_DEVICE_ID    = 8'h00;

    // Control A field positions
    localparam int BIT_STANDBY_PD = 7;
    localparam int BIT_TAIL_PN    = 6;
    localparam int BIT_TEST_EN    = 5;
    localparam int BIT_LANE_SYNC  = 4;
    localparam int POS_ALIGN_MODE = 2;
    localparam int BIT_FRAME_ALIGN_DIS = 1;
    localparam int BIT_LINK_PD    = 0;

    // Control B field positions and writable mask
    localparam int         BIT_SYNC_INV    = 5;
    localparam int         BIT_ENC_BYPASS  = 2;
    localparam int         BIT_TX_INVERT   = 1;
    localparam int         BIT_TX_MIRROR   = 0;
    localparam logic [7:0] MASK_LINK_CTRL_B = 8'h27;

    // Test and checksum field positions
    localparam int BIT_CKSUM_DIS  = 7;
    localparam int BIT_CKSUM_ALG  = 6;
    localparam int POS_INJECT_SEL = 4;
    localparam int POS_PATTERN    = 0;

    // Alignment sequence: multiframes before the extra frames
    localparam int ALIGN_BASE_MULTIFRAMES = 4;

    // Alignment sequence modes
    typedef enum logic [1:0] {
        SLTC_ALIGN_OFF      = 2'b00,
        SLTC_ALIGN_ON       = 2'b01,
        SLTC_ALIGN_ALWAYS   = 2'b10,
        SLTC_ALIGN_RESERVED = 2'b11
    } sltc_align_mode_t;

    // Test data injection points
    typedef enum logic [1:0] {
        SLTC_INJ_NONE0 = 2'b00,
        SLTC_INJ_10B   = 2'b01,
        SLTC_INJ_8B    = 2'b10,
        SLTC_INJ_NONE3 = 2'b11
    } sltc_inject_t;

    // Test pattern codes
    localparam logic [3:0] PAT_OFF      = 4'h0;
    localparam logic [3:0] PAT_ALT      = 4'h1;
    localparam logic [3:0] PAT_TOGGLE   = 4'h2;
    localparam logic [3:0] PAT_PN_LONG  = 4'h3;
    localparam logic [3:0] PAT_PN_SHORT = 4'h4;
    localparam logic [3:0] PAT_USER     = 4'h6;
    localparam logic [3:0] PAT_RAMP     = 4'h7;
    localparam logic [3:0] PAT_MODIFIED = 4'h8;

    // Pattern constants
    localparam logic [9:0]  ALT_WORD      = 10'h2aa;
    localparam logic [22:0] PN_LONG_SEED  = 23'h7fffff;
    localparam logic [8:0]  PN_SHORT_SEED = 9'h1ff;
    localparam logic [14:0] TAIL_PN_SEED  = 15'h7fff;

    // Decoded link controls seen by the rest of the transmitter
    typedef struct packed {
        logic             link_powered;
        logic             tail_pn;
        logic             test_mode;
        logic             lane_sync_en;
        sltc_align_mode_t align_mode;
        logic             frame_align_char_insertion;
        logic             encoder_used;
        logic             cksum_en;
        logic             cksum_packed;
        sltc_inject_t     inject_sel;
        logic [3:0]       pattern_sel;
    } sltc_link_ctrl_t;

endpackage

// file: hw/sltc_top.sv
// Serial link transmit configuration: registers, decoded controls and the
// symbol-side effects (tail bits, test injection, invert, mirror, sync polarity).
// Assumes a byte-wide register port clocked by mclk and a lane of one
// 10-bit symbol per cycle.
`timescale 1ns/1ps

module sltc_top
    import sltc_pkg::*;
#(
    parameter int         SAMPLE_W  = 14,          // Converter sample width
    parameter logic [9:0] USER_WORD = 10'h17c      // Single user word pattern
)(
    input  wire logic                  mclk,            // Converter clock
    input  wire logic                  rst_n,           // Async reset, active low
    input  wire logic [8:0]            reg_addr,        // Register address
    input  wire logic                  reg_wr,          // Register write strobe
    input  wire logic                  reg_rd,          // Register read strobe
    input  wire logic [7:0]            reg_wdata,       // Register write data
    output logic      [7:0]            reg_rdata,       // Register read data
    output logic                       reg_rvalid,      // Read data valid pulse
    input  wire logic                  standby,         // Device in standby
    input  wire logic [4:0]            frames_per_mf,   // Frames per multiframe
    input  wire logic                  sync_request_input, // Raw sync request
    input  wire logic [SAMPLE_W-1:0]   sample_in,       // Converter sample
    input  wire logic [7:0]            scr_data_in,     // Octet to scrambler
    input  wire logic [9:0]            enc_sym_in,      // Encoder output symbol
    output logic [SAMPLE_W+1:0]        sample_word,     // Sample plus tail bits
    output logic [7:0]                 scr_data_out,    // Octet after injection
    output logic [9:0]                 serial_lane_outputs, // Symbol to serialiser
    output logic                       sync_request,    // Sync request, active high
    output sltc_link_ctrl_t            link_ctrl,       // Decoded link controls
    output logic [10:0]                align_frames,    // Alignment length in frames
    output logic [7:0]                 device_id        // Link device identifier
);

    localparam int TAIL_W = 2;                  // Tail bits below each sample

    logic [7:0]      ctrl_a_ff;
    logic [7:0]      ctrl_b_ff;
    logic [7:0]      test_ck_ff;
    logic [7:0]      align_rep_ff;
    logic [7:0]      dev_id_ff;
    logic [7:0]      nxt_rdata;
    logic [22:0]     pn_long_ff;
    logic [8:0]      pn_short_ff;
    logic [14:0]     tail_pn_ff;
    logic [9:0]      ramp_ff;
    logic            toggle_ff;
    logic [9:0]      nxt_pattern;
    logic [9:0]      nxt_sym;
    logic [9:0]      mirrored;
    logic            test_active;
    sltc_inject_t    inj_sel;
    logic [TAIL_W-1:0] nxt_tail;

    // Register writes
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_a_ff    <= RST_LINK_CTRL_A;
            ctrl_b_ff    <= RST_LINK_CTRL_B;
            test_ck_ff   <= RST_TEST_CKSUM;
            align_rep_ff <= RST_ALIGN_REPEAT;
            dev_id_ff    <= RST_DEVICE_ID;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                ADDR_LINK_CTRL_A:  ctrl_a_ff    <= reg_wdata;
                ADDR_LINK_CTRL_B:  ctrl_b_ff    <= reg_wdata & MASK_LINK_CTRL_B;
                ADDR_TEST_CKSUM:   test_ck_ff   <= reg_wdata;
                ADDR_ALIGN_REPEAT: align_rep_ff <= reg_wdata;
                ADDR_DEVICE_ID:    dev_id_ff    <= reg_wdata;
                default:           ;
            endcase
        end
    end

    // Read mux, unmapped addresses read zero
    always_comb
    begin
        unique case (reg_addr)
            ADDR_LINK_CTRL_A:  nxt_rdata = ctrl_a_ff;
            ADDR_LINK_CTRL_B:  nxt_rdata = ctrl_b_ff;
            ADDR_TEST_CKSUM:   nxt_rdata = test_ck_ff;
            ADDR_ALIGN_REPEAT: nxt_rdata = align_rep_ff;
            ADDR_DEVICE_ID:    nxt_rdata = dev_id_ff;
            default:           nxt_rdata = 8'h00;
        endcase
    end

    // Registered read answer, one cycle after the strobe
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
            begin
                reg_rdata <= nxt_rdata;
            end
        end
    end

    // Decoded controls
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link_ctrl    <= '0;
            align_frames <= 11'h000;
            device_id    <= 8'h00;
        end
        else
        begin
            link_ctrl.link_powered <= !ctrl_a_ff[BIT_LINK_PD]
                                      && !(standby && ctrl_a_ff[BIT_STANDBY_PD]);
            link_ctrl.tail_pn      <= ctrl_a_ff[BIT_TAIL_PN];
            link_ctrl.test_mode    <= ctrl_a_ff[BIT_TEST_EN];
            link_ctrl.lane_sync_en <= ctrl_a_ff[BIT_LANE_SYNC];
            link_ctrl.align_mode   <= sltc_align_mode_t'(ctrl_a_ff[POS_ALIGN_MODE +: 2]);
            link_ctrl.frame_align_char_insertion <= !ctrl_a_ff[BIT_FRAME_ALIGN_DIS];
            link_ctrl.encoder_used <= !ctrl_b_ff[BIT_ENC_BYPASS];
            link_ctrl.cksum_en     <= !test_ck_ff[BIT_CKSUM_DIS];
            link_ctrl.cksum_packed <= test_ck_ff[BIT_CKSUM_ALG];
            link_ctrl.inject_sel   <= sltc_inject_t'(test_ck_ff[POS_INJECT_SEL +: 2]);
            link_ctrl.pattern_sel  <= test_ck_ff[POS_PATTERN +: 4];
            // Four multiframes of K frames, plus count plus one frames
            align_frames <= 11'(ALIGN_BASE_MULTIFRAMES) * {6'h00, frames_per_mf}
                            + {3'h0, align_rep_ff} + 11'h001;
            device_id    <= dev_id_ff;
        end
    end

    // Sync request, normal polarity is active low on the pin
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_request <= 1'b0;
        end
        else
        begin
            sync_request <= !(sync_request_input ^ ctrl_b_ff[BIT_SYNC_INV]);
        end
    end

    // Pattern sources: PN sequences, ramp, toggle
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pn_long_ff  <= PN_LONG_SEED;
            pn_short_ff <= PN_SHORT_SEED;
            ramp_ff     <= 10'h000;
            toggle_ff   <= 1'b0;
        end
        else
        begin
            pn_long_ff  <= {pn_long_ff[21:0], pn_long_ff[22] ^ pn_long_ff[17]};
            pn_short_ff <= {pn_short_ff[7:0], pn_short_ff[8] ^ pn_short_ff[4]};
            ramp_ff     <= ramp_ff + 10'h001;
            toggle_ff   <= !toggle_ff;
        end
    end

    // Tail bit generator
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tail_pn_ff <= TAIL_PN_SEED;
        end
        else
        begin
            tail_pn_ff <= {tail_pn_ff[13:0], tail_pn_ff[14] ^ tail_pn_ff[13]};
        end
    end

    // Test pattern select
    always_comb
    begin
        unique case (test_ck_ff[POS_PATTERN +: 4])
            PAT_ALT:      nxt_pattern = toggle_ff ? ~ALT_WORD : ALT_WORD;
            PAT_TOGGLE:   nxt_pattern = {10{toggle_ff}};
            PAT_PN_LONG:  nxt_pattern = pn_long_ff[9:0];
            PAT_PN_SHORT: nxt_pattern = {pn_short_ff, pn_short_ff[8]};
            PAT_USER:     nxt_pattern = USER_WORD;
            PAT_RAMP:     nxt_pattern = ramp_ff;
            PAT_MODIFIED: nxt_pattern = ramp_ff ^ ALT_WORD;
            default:      nxt_pattern = 10'h000;
        endcase
    end

    // Injection only while test mode is enabled and a pattern chosen
    assign test_active = ctrl_a_ff[BIT_TEST_EN]
                         && (test_ck_ff[POS_PATTERN +: 4] != PAT_OFF);
    assign inj_sel     = sltc_inject_t'(test_ck_ff[POS_INJECT_SEL +: 2]);

    // Encoder output or bypass, then 10-bit injection
    always_comb
    begin
        if (test_active && (inj_sel == SLTC_INJ_10B))
        begin
            nxt_sym = nxt_pattern;
        end
        else if (ctrl_b_ff[BIT_ENC_BYPASS])
        begin
            nxt_sym = {2'b00, scr_data_in};
        end
        else
        begin
            nxt_sym = enc_sym_in;
        end
    end

    // Bit order reversal
    for (genvar i = 0; i < 10; i++)
    begin : g_mirror
        assign mirrored[i] = nxt_sym[9-i];
    end

    // Symbol output with mirror and invert
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            serial_lane_outputs <= 10'h000;
        end
        else
        begin
            serial_lane_outputs <= (ctrl_b_ff[BIT_TX_MIRROR] ? mirrored : nxt_sym)
                                   ^ {10{ctrl_b_ff[BIT_TX_INVERT]}};
        end
    end

    // Octet to scrambler, with 8-bit injection
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scr_data_out <= 8'h00;
        end
        else if (test_active && (inj_sel == SLTC_INJ_8B))
        begin
            scr_data_out <= nxt_pattern[7:0];
        end
        else
        begin
            scr_data_out <= scr_data_in;
        end
    end

    // Tail bits: zeros by default, pseudo-random when chosen
    always_comb
    begin
        if (ctrl_a_ff[BIT_TAIL_PN])
        begin
            nxt_tail = tail_pn_ff[TAIL_W-1:0];
        end
        else
        begin
            nxt_tail = '0;
        end
    end

    // Sample word with tail bits
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sample_word <= '0;
        end
        else
        begin
            sample_word <= {sample_in, nxt_tail};
        end
    end

endmodule // sltc_top

// file: testbench/sltc_props.sv
// Port checks for the link configuration block.
// Bound to sltc_top below; sees its ports only.
`timescale 1ns/1ps
module sltc_props
    import sltc_pkg::*;
#(
    parameter int SAMPLE_W = 14 // Sample width
)(
    input wire logic                mclk,               // Clock
    input wire logic                rst_n,              // Reset
    input wire logic [8:0]          reg_addr,           // Address
    input wire logic                reg_wr,             // Write
    input wire logic                reg_rd,             // Read
    input wire logic [7:0]          reg_wdata,          // Write data
    input wire logic                reg_rvalid,         // Read valid
    input wire logic                standby,            // Standby
    input wire logic [4:0]          frames_per_mf,      // Frames per mf
    input wire logic                sync_request_input, // Sync pin
    input wire logic [7:0]          scr_data_in,        // Octet in
    input wire logic [SAMPLE_W+1:0] sample_word,        // Sample out
    input wire logic [7:0]          scr_data_out,       // Octet out
    input wire logic                sync_request,       // Sync out
    input wire sltc_link_ctrl_t     link_ctrl,          // Controls
    input wire logic [10:0]         align_frames,       // Align length
    input wire logic [7:0]          device_id           // Identifier
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Identifier write, then its copy two edges on
    sequence id_write;
        reg_wr && reg_addr == ADDR_DEVICE_ID;
    endsequence
    sequence id_seen;
        ##2 device_id == $past(reg_wdata, 2);
    endsequence
    // Read valid follows the read strobe one cycle later
    rvalid_pulse_a: assert property ($past(rst_n) |-> reg_rvalid == $past(reg_rd))
        else $error("read valid not one cycle after read");
    id_copy_a: assert property (id_write |-> id_seen)
        else $error("identifier not copied");
    tail_zero_a: assert property (!link_ctrl.tail_pn && !$past(link_ctrl.tail_pn)
        |-> sample_word[1:0] == 2'b00) else $error("tail bits not zero");
    scr_pass_a: assert property (!link_ctrl.test_mode && !$past(link_ctrl.test_mode)
        && $past(rst_n, 2) |-> scr_data_out == $past(scr_data_in))
        else $error("octet altered outside test mode");
    power_cause_a: assert property ($fell(link_ctrl.link_powered)
        |-> $past(standby) || $past(reg_wr, 2)) else $error("link powered down uncaused");
    defaults_fall_a: assert property ($fell(link_ctrl.encoder_used)
        || $fell(link_ctrl.frame_align_char_insertion) || $fell(link_ctrl.cksum_en)
        |-> $past(reg_wr, 2)) else $error("default enable dropped uncaused");
    sync_cause_a: assert property ($changed(sync_request) && $past(rst_n, 3)
        |-> $past(sync_request_input) != $past(sync_request_input, 2) || $past(reg_wr, 2))
        else $error("sync request changed uncaused");
    align_floor_a: assert property ($past(rst_n)
        |-> align_frames >= {4'h0, $past(frames_per_mf), 2'b00} + 11'h001)
        else $error("alignment length below minimum");
endmodule // sltc_props

bind sltc_top sltc_props #(.SAMPLE_W(SAMPLE_W)) i_props (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid), .standby(standby),
    .frames_per_mf(frames_per_mf), .sync_request_input(sync_request_input),
    .scr_data_in(scr_data_in), .sample_word(sample_word), .scr_data_out(scr_data_out),
    .sync_request(sync_request), .link_ctrl(link_ctrl), .align_frames(align_frames),
    .device_id(device_id)
);

// file: testbench/sltc_rx_model.sv
// Receiver model: drives the sync pin and undoes invert and mirror.
// The bench gives it the same lane settings as the transmitter.
`timescale 1ns/1ps
module sltc_rx_model (
    input  wire logic [9:0] lane,              // Received symbol
    input  wire logic       pol_inv,           // Sync polarity set
    input  wire logic       rx_inv,            // Invert set
    input  wire logic       rx_mir,            // Mirror set
    input  wire logic       want,              // Request sync
    output logic            sync_pin,          // Sync pin level
    output logic [9:0]      rx_sym             // Restored symbol
);
    // Pin low requests sync unless inverted
    assign sync_pin = pol_inv ? want : !want;
    // Undo invert, then mirror
    always_comb
    begin
        for (int i = 0; i < 10; i++)
        begin
            rx_sym[i] = lane[rx_mir ? 9 - i : i] ^ rx_inv;
        end
    end
endmodule // sltc_rx_model

// file: testbench/serial_link_tx_config_tb.sv
// Self-checking bench for the link configuration block.
// Needs sltc_pkg, sltc_top, sltc_rx_model and the bound checker.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin err_total++; \
    $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module serial_link_tx_config_tb;
    import sltc_pkg::*;
    logic            mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [8:0]      reg_addr = 9'h000;
    logic [7:0]      reg_wdata = 8'h00, reg_rdata, scr_data_in = 8'h00, scr_data_out;
    logic            reg_rvalid, standby = 1'b0, sync_pin, sync_request;
    logic [4:0]      frames_per_mf = 5'h03;
    logic [13:0]     sample_in = 14'h1abc;
    logic [15:0]     sample_word;
    logic [9:0]      enc_sym_in = 10'h1c5, lane, rx_sym;
    logic            pol_inv = 1'b0, rx_inv = 1'b0, rx_mir = 1'b0, want = 1'b0;
    sltc_link_ctrl_t link_ctrl;
    logic [10:0]     align_frames;
    logic [7:0]      device_id;
    int              err_total = 0, check_count = 0;

    // 250 MHz clock
    always #2 mclk = ~mclk;

    sltc_top i_dut (
        .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .standby(standby), .frames_per_mf(frames_per_mf), .sync_request_input(sync_pin),
        .sample_in(sample_in), .scr_data_in(scr_data_in), .enc_sym_in(enc_sym_in),
        .sample_word(sample_word), .scr_data_out(scr_data_out), .serial_lane_outputs(lane),
        .sync_request(sync_request), .link_ctrl(link_ctrl), .align_frames(align_frames),
        .device_id(device_id)
    );
    sltc_rx_model i_rx (
        .lane(lane), .pol_inv(pol_inv), .rx_inv(rx_inv),
        .rx_mir(rx_mir), .want(want), .sync_pin(sync_pin), .rx_sym(rx_sym)
    );

    // Bus cycles and settling
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] ex);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        `CHK("read valid", 1'b1, reg_rvalid)
        `CHK("read data", ex, reg_rdata)
    endtask
    // Expected lane symbol after mirror and invert
    function automatic logic [9:0] txform(input logic [9:0] s, input logic inv, mir);
        logic [9:0] r;
        for (int i = 0; i < 10; i++) r[i] = (mir ? s[9 - i] : s[i]) ^ inv;
        return r;
    endfunction

    // Reset values of registers and decoded controls
    task automatic t_reset;
        for (int i = 0; i < 5; i++) rd(ADDR_LINK_CTRL_A + 9'(i), 8'h00);
        `CHK("controls", 16'h8380, link_ctrl)
        `CHK("align len", 11'd13, align_frames)
    endtask
    // Control A fields, standby and tail bits
    task automatic t_ctrl_a;
        logic [1:0] acc;
        for (int m = 0; m < 4; m++)
        begin
            wr(ADDR_LINK_CTRL_A, 8'h12 | 8'(m << 2));
            step(1);
            `CHK("align mode", 2'(m), link_ctrl.align_mode)
            `CHK("lane sync", 1'b1, link_ctrl.lane_sync_en)
            `CHK("align char", 1'b0, link_ctrl.frame_align_char_insertion)
        end
        wr(ADDR_LINK_CTRL_A, 8'h00);
        standby <= 1'b1;
        step(2);
        `CHK("standby up", 1'b1, link_ctrl.link_powered)
        wr(ADDR_LINK_CTRL_A, 8'h80);
        step(1);
        `CHK("standby down", 1'b0, link_ctrl.link_powered)
        @(posedge mclk);
        standby <= 1'b0;
        step(1);
        `CHK("awake", 1'b1, link_ctrl.link_powered)
        wr(ADDR_LINK_CTRL_A, 8'h41);
        step(1);
        `CHK("link down", 2'b01, {link_ctrl.link_powered, link_ctrl.tail_pn})
        acc = 2'b00;
        repeat (8)
        begin
            step(1);
            acc = acc | sample_word[1:0];
        end
        `CHK("tail pn", 1'b1, |acc)
        `CHK("sample", sample_in, sample_word[15:2])
    endtask
    // Checksum, injection point and pattern codes
    task automatic t_ctrl3;
        logic [7:0] x;
        wr(ADDR_TEST_CKSUM, 8'hc0);
        step(1);
        `CHK("cksum", 2'b01, {link_ctrl.cksum_en, link_ctrl.cksum_packed})
        for (int p = 0; p < 9; p++)
        begin
            wr(ADDR_TEST_CKSUM, 8'h20 | 8'(p));
            step(2);
            `CHK("pattern", 4'(p), link_ctrl.pattern_sel)
            `CHK("no test", scr_data_in, scr_data_out)
        end
        wr(ADDR_LINK_CTRL_A, 8'h20);
        wr(ADDR_TEST_CKSUM, 8'h26);
        step(2);
        `CHK("user octet", 8'h7c, scr_data_out)
        `CHK("test on", 3'b110, {link_ctrl.test_mode, link_ctrl.inject_sel})
        wr(ADDR_TEST_CKSUM, 8'h22);
        step(2);
        x = scr_data_out;
        step(1);
        `CHK("toggle", ~x, scr_data_out)
        wr(ADDR_TEST_CKSUM, 8'h21);
        step(2);
        x = scr_data_out;
        step(1);
        `CHK("alternating", ~x, scr_data_out)
        `CHK("alt word", 1'b1, x == ALT_WORD[7:0] || x == ~ALT_WORD[7:0])
        wr(ADDR_TEST_CKSUM, 8'h27);
        step(2);
        x = scr_data_out;
        step(1);
        `CHK("ramp", x + 8'h01, scr_data_out)
        wr(ADDR_TEST_CKSUM, 8'h20);
        step(2);
        `CHK("pattern off", scr_data_in, scr_data_out)
        wr(ADDR_TEST_CKSUM, 8'h36);
        step(2);
        `CHK("inject none", scr_data_in, scr_data_out)
        wr(ADDR_TEST_CKSUM, 8'h16);
        step(2);
        `CHK("user symbol", 10'h17c, lane)
        wr(ADDR_LINK_CTRL_A, 8'h00);
        wr(ADDR_TEST_CKSUM, 8'h00);
    endtask
    // Invert, mirror, bypass and register mask
    task automatic t_lane;
        for (int c = 0; c < 4; c++)
        begin
            wr(ADDR_LINK_CTRL_B, 8'(c));
            rx_inv <= c[1];
            rx_mir <= c[0];
            step(2);
            `CHK("lane", txform(enc_sym_in, c[1], c[0]), lane)
            `CHK("restored", enc_sym_in, rx_sym)
        end
        wr(ADDR_LINK_CTRL_B, 8'h04);
        rx_inv <= 1'b0;
        rx_mir <= 1'b0;
        step(2);
        `CHK("bypass", {2'b00, scr_data_in}, lane)
        wr(ADDR_LINK_CTRL_B, 8'hff);
        rd(ADDR_LINK_CTRL_B, 8'h27);
        wr(9'h147, 8'h5a);
        rd(9'h147, 8'h00);
        wr(ADDR_LINK_CTRL_B, 8'h00);
    endtask
    // Sync request under both polarities
    task automatic t_sync;
        for (int p = 0; p < 4; p++)
        begin
            wr(ADDR_LINK_CTRL_B, p[1] ? 8'h20 : 8'h00);
            pol_inv <= p[1];
            want <= p[0];
            step(2);
            `CHK("sync", p[0], sync_request)
        end
    endtask
    // Alignment length, identifier and reset in mid-run
    task automatic t_align;
        wr(ADDR_ALIGN_REPEAT, 8'h01);
        step(2);
        `CHK("align one", 11'd14, align_frames)
        wr(ADDR_ALIGN_REPEAT, 8'hff);
        frames_per_mf <= 5'h1f;
        step(2);
        `CHK("align max", 11'd380, align_frames)
        wr(ADDR_DEVICE_ID, 8'ha5);
        step(2);
        `CHK("identifier", 8'ha5, device_id)
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        step(2);
        rd(ADDR_ALIGN_REPEAT, 8'h00);
        `CHK("controls again", 16'h8380, link_ctrl)
        `CHK("align reset", 11'd125, align_frames)
        `CHK("id cleared", 8'h00, device_id)
    endtask

    // Counts and verdict
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        scr_data_in <= 8'h3c;
        step(2);
        t_reset();
        t_ctrl_a();
        t_ctrl3();
        t_lane();
        t_sync();
        t_align();
        complete_run();
    end
    // Watchdog, about twenty-five times the expected run
    initial
    begin
        repeat (5000) @(posedge mclk);
        err_total++;
        complete_run();
    end
endmodule // serial_link_tx_config_tb
